// ---- logic/fbsp_pkg.sv ----
// constants shared by the flow-through burst memory port
package fbsp_pkg;
   // ==========================================================
   // geometry
   localparam int ADDR_W     = 21;
   localparam int LANE_W     = 9;
   localparam int DATA_W     = 18;
   localparam int BURST_W    = 2;
   localparam int FIFO_DEPTH = 8;
   // ==========================================================
   // field positions inside a queued write entry
   localparam int ENT_DATA_LSB  = 0;
   localparam int ENT_LANE_LSB  = 18;
   localparam int ENT_ADDR_LSB  = 20;
   // ==========================================================
   // reset values
   localparam logic [BURST_W-1:0] RST_COUNT = 2'h0;
   localparam logic [DATA_W-1:0]  RST_RDATA = 18'h0_0000;
   // ==========================================================
   // burst kind fixed by the load cycle
   typedef enum logic [1:0]
   {
      FBSP_IDLE  = 2'b00,
      FBSP_READ  = 2'b01,
      FBSP_WRITE = 2'b10
   } fbsp_mode_e;
endpackage : fbsp_pkg

// ---- logic/fbsp_fifo.sv ----
// queue of late-write entries between the pins and the array
`timescale 1ns/10ps
module fbsp_fifo
#(
   parameter int WIDTH = 40,
   parameter int DEPTH = 8
)
(
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int PW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1)
   begin : g_bad_depth
      $error("fifo depth must be a power of two, two or more");
   end

   // ==========================================================
   // state
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW:0]                 wr;
      logic [PW:0]                 rd;
   } fbsp_fifo_s;

   fbsp_fifo_s st;
   fbsp_fifo_s next_st;

   logic full;
   logic empty;

   assign full      = (st.wr[PW] != st.rd[PW]) &&
                      (st.wr[PW-1:0] == st.rd[PW-1:0]);
   assign empty     = (st.wr == st.rd);
   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = st.mem[st.rd[PW-1:0]];

   always_comb
   begin
      next_st = st;
      if (in_valid && !full)
      begin
         next_st.mem[st.wr[PW-1:0]] = in_data;
         next_st.wr = st.wr + {{PW{1'b0}}, 1'b1};
      end
      if (out_ready && !empty)
         next_st.rd = st.rd + {{PW{1'b0}}, 1'b1};
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
         st <= '0;
      else
         st <= next_st;
   end
endmodule : fbsp_fifo

// ---- logic/fbsp_port.sv ----
// flow-through burst memory with late write, device side
// Notes on behaviour
// - sleep pin asynchronous, deselects while high
// - in sleep, inputs ignored, data high-Z
// - interleaved order: start xor count
// - linear order: start plus count
// - two-bit counter wraps every four cycles
// - continue cycles of a read or write burst advance the counter
// - any inactive chip select loads deselect
// - advance after deselect stays deselected
// - active selects, read high begin read
// - continue ignores selects, kind fixed at load
// - dummy read and write abort are no-ops
// - write with no lanes changes nothing
// - lane a low byte, lane b high
// - drivers off during write cycles
// - clock hold freezes state, no write
// - sync inputs on rising edge, enable async
// - data high-Z from power-up
// - write data one cycle after command
// - read data in cycle after the edge
`timescale 1ns/10ps
module fbsp_port
#(
   parameter int ADDR_W     = fbsp_pkg::ADDR_W,
   parameter int FIFO_DEPTH = fbsp_pkg::FIFO_DEPTH
)
(
   input  wire logic                      sys_clk,
   input  wire logic                      resetn,
   input  wire logic                      sleep_request,
   input  wire logic                      burst_order_select_n,
   input  wire logic                      advance_or_load,
   input  wire logic                      read_not_write,
   input  wire logic [ADDR_W-1:0]         address,
   input  wire logic                      chip_select_first_n,
   input  wire logic                      chip_select_second,
   input  wire logic                      chip_select_third_n,
   input  wire logic                      byte_write_lane_a_n,
   input  wire logic                      byte_write_lane_b_n,
   input  wire logic                      clock_hold_n,
   input  wire logic                      output_enable_n,
   input  wire logic [fbsp_pkg::LANE_W-1:0] data_lane_a_in,
   input  wire logic [fbsp_pkg::LANE_W-1:0] data_lane_b_in,
   output logic [fbsp_pkg::LANE_W-1:0]    data_lane_a_out,
   output logic [fbsp_pkg::LANE_W-1:0]    data_lane_b_out,
   output logic                           data_oe,
   output logic                           write_ready
);
   localparam int DW = fbsp_pkg::DATA_W;
   localparam int LW = fbsp_pkg::LANE_W;
   localparam int EW = ADDR_W + 2 + DW;

   if (ADDR_W < 3 || ADDR_W > fbsp_pkg::ADDR_W)
   begin : g_bad_addr
      $error("address width out of range");
   end
   if (2 * LW != DW)
   begin : g_bad_lanes
      $error("two lanes must fill the data word");
   end

   // ==========================================================
   // state
   typedef struct packed {
      fbsp_pkg::fbsp_mode_e              mode;
      logic [ADDR_W-1:0]                 base;
      logic [fbsp_pkg::BURST_W-1:0]      count;
      logic                              drive;
      logic [DW-1:0]                     rdata;
      logic                              wr_pending;
      logic [ADDR_W-1:0]                 wr_addr;
   } fbsp_state_s;

   fbsp_state_s st;
   fbsp_state_s next_st;

   // array kept outside the state record for its size
   logic [DW-1:0] mem [0:(1<<ADDR_W)-1];

   logic              held;
   logic              active;
   logic              deselect_cmd;
   logic              load;
   logic              cont;
   logic [1:0]        next_count;
   logic [ADDR_W-1:0] cur_addr;
   logic [ADDR_W-1:0] step_addr;
   logic [ADDR_W-1:0] rd_addr;
   logic              rd_en;
   logic              push;
   logic [EW-1:0]     push_ent;
   logic              fifo_out_valid;
   logic              fifo_out_ready;
   logic [EW-1:0]     head;
   logic [1:0]        head_lanes_n;
   logic [ADDR_W-1:0] head_addr;
   logic [DW-1:0]     head_data;
   logic [DW-1:0]     rd_word;
   logic [DW-1:0]     in_word;

   // ==========================================================
   // command decode
   assign held         = clock_hold_n;
   assign active       = !sleep_request && !held;
   assign load         = active && !advance_or_load;
   assign cont         = active && advance_or_load;
   assign deselect_cmd = chip_select_first_n || !chip_select_second ||
                         chip_select_third_n;
   assign next_count   = st.count + 2'h1;

   // address of the current and of the next burst beat
   always_comb
   begin
      cur_addr  = st.base;
      step_addr = st.base;
      if (burst_order_select_n)
      begin
         cur_addr[1:0]  = st.base[1:0] ^ st.count;
         step_addr[1:0] = st.base[1:0] ^ next_count;
      end
      else
      begin
         cur_addr[1:0]  = st.base[1:0] + st.count;
         step_addr[1:0] = st.base[1:0] + next_count;
      end
   end

   // ==========================================================
   // late write queue
   assign in_word  = {data_lane_b_in, data_lane_a_in};
   assign push     = active && st.wr_pending &&
                     !(byte_write_lane_a_n && byte_write_lane_b_n);
   assign push_ent = {st.wr_addr, byte_write_lane_b_n,
                      byte_write_lane_a_n, in_word};
   assign fifo_out_ready = active;
   assign head_data    = head[fbsp_pkg::ENT_DATA_LSB +: DW];
   assign head_lanes_n = head[fbsp_pkg::ENT_LANE_LSB +: 2];
   assign head_addr    = head[fbsp_pkg::ENT_ADDR_LSB +: ADDR_W];

   fbsp_fifo
   #(
      .WIDTH (EW),
      .DEPTH (FIFO_DEPTH)
   )
   u_queue
   (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .in_valid  (push),
      .in_ready  (write_ready),
      .in_data   (push_ent),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (head)
   );

   // ==========================================================
   // read path with forwarding of queued and arriving data
   always_comb
   begin
      rd_word = mem[rd_addr];
      if (fifo_out_valid && head_addr == rd_addr)
      begin
         if (!head_lanes_n[0])
            rd_word[LW-1:0] = head_data[LW-1:0];
         if (!head_lanes_n[1])
            rd_word[DW-1:LW] = head_data[DW-1:LW];
      end
      if (push && st.wr_addr == rd_addr)
      begin
         if (!byte_write_lane_a_n)
            rd_word[LW-1:0] = data_lane_a_in;
         if (!byte_write_lane_b_n)
            rd_word[DW-1:LW] = data_lane_b_in;
      end
   end

   // ==========================================================
   // control state
   always_comb
   begin
      next_st = st;
      rd_en   = 1'b0;
      rd_addr = address;
      if (sleep_request)
      begin
         next_st.mode       = fbsp_pkg::FBSP_IDLE;
         next_st.drive      = 1'b0;
         next_st.wr_pending = 1'b0;
      end
      else if (!held)
      begin
         next_st.drive      = 1'b0;
         next_st.wr_pending = 1'b0;
         if (load)
         begin
            next_st.base  = address;
            next_st.count = fbsp_pkg::RST_COUNT;
            if (deselect_cmd)
               next_st.mode = fbsp_pkg::FBSP_IDLE;
            else if (read_not_write)
            begin
               next_st.mode  = fbsp_pkg::FBSP_READ;
               next_st.drive = 1'b1;
               rd_en         = 1'b1;
            end
            else
            begin
               next_st.mode       = fbsp_pkg::FBSP_WRITE;
               next_st.wr_pending = 1'b1;
               next_st.wr_addr    = address;
            end
         end
         else
         begin
            case (st.mode)
               fbsp_pkg::FBSP_IDLE:
                  next_st.mode = fbsp_pkg::FBSP_IDLE;
               fbsp_pkg::FBSP_READ:
               begin
                  next_st.count = next_count;
                  next_st.drive = 1'b1;
                  rd_addr       = step_addr;
                  rd_en         = 1'b1;
               end
               fbsp_pkg::FBSP_WRITE:
               begin
                  next_st.count      = next_count;
                  next_st.wr_pending = 1'b1;
                  next_st.wr_addr    = step_addr;
               end
               default:
                  next_st.mode = fbsp_pkg::FBSP_IDLE;
            endcase
         end
         if (rd_en)
            next_st.rdata = rd_word;
      end
   end

   always_ff @(posedge sys_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st.mode       <= fbsp_pkg::FBSP_IDLE;
         st.base       <= '0;
         st.count      <= fbsp_pkg::RST_COUNT;
         st.drive      <= 1'b0;
         st.rdata      <= fbsp_pkg::RST_RDATA;
         st.wr_pending <= 1'b0;
         st.wr_addr    <= '0;
      end
      else
         st <= next_st;
   end

   // array write from the queue head, per byte lane
   always_ff @(posedge sys_clk)
   begin
      if (fifo_out_valid && fifo_out_ready)
      begin
         if (!head_lanes_n[0])
            mem[head_addr][LW-1:0] <= head_data[LW-1:0];
         if (!head_lanes_n[1])
            mem[head_addr][DW-1:LW] <= head_data[DW-1:LW];
      end
   end

   // ==========================================================
   // pins
   assign data_lane_a_out = st.rdata[LW-1:0];
   assign data_lane_b_out = st.rdata[DW-1:LW];
   assign data_oe = st.drive && !output_enable_n && !sleep_request;

   // ==========================================================
   // checks
   AST_SLEEP_HIZ: assert property (@(posedge sys_clk)
      disable iff (!resetn)
      sleep_request |-> !data_oe ##1 !st.drive)
      else $error("data driven in sleep");
   AST_DESEL_HIZ: assert property (@(posedge sys_clk)
      disable iff (!resetn)
      load && deselect_cmd |=> !data_oe && st.mode == fbsp_pkg::FBSP_IDLE)
      else $error("deselect did not float data");
   AST_CONT_DESEL: assert property (@(posedge sys_clk)
      disable iff (!resetn)
      cont && st.mode == fbsp_pkg::FBSP_IDLE |=> !st.drive)
      else $error("continued deselect drove data");
   AST_READ_FLOW: assert property (@(posedge sys_clk)
      disable iff (!resetn)
      load && !deselect_cmd && read_not_write |=> st.drive)
      else $error("read data not presented next cycle");
   AST_WRITE_NODRV: assert property (@(posedge sys_clk)
      disable iff (!resetn)
      load && !deselect_cmd && !read_not_write |=> !data_oe)
      else $error("drivers on during write");
   AST_LATE_WRITE: assert property (@(posedge sys_clk)
      disable iff (!resetn)
      load && !deselect_cmd && !read_not_write
      |=> st.wr_pending && st.wr_addr == $past(address))
      else $error("write data phase not armed");
   AST_STEP: assert property (@(posedge sys_clk)
      disable iff (!resetn)
      cont && st.mode != fbsp_pkg::FBSP_IDLE
      |=> st.count == 2'($past(st.count) + 2'h1))
      else $error("burst counter did not advance");
   AST_WRAP: assert property (@(posedge sys_clk)
      disable iff (!resetn)
      (cont && st.mode == fbsp_pkg::FBSP_READ)[*4]
      |=> cur_addr == $past(cur_addr, 4))
      else $error("burst did not wrap after four");
   AST_HOLD: assert property (@(posedge sys_clk)
      disable iff (!resetn)
      clock_hold_n && !sleep_request |-> !fifo_out_ready && !push
      ##1 st.drive == $past(st.drive) && $stable(st.rdata))
      else $error("state moved under clock hold");
   AST_NO_LANE: assert property (@(posedge sys_clk)
      disable iff (!resetn)
      byte_write_lane_a_n && byte_write_lane_b_n |-> !push)
      else $error("empty write was queued");
endmodule : fbsp_port

// ---- bench/fbsp_ctrl_model.sv ----
// memory controller model: commands, address and late write data
`timescale 1ns/10ps
module fbsp_ctrl_model
(
   input  wire logic                        sys_clk,
   output logic                             advance_or_load,
   output logic                             read_not_write,
   output logic [fbsp_pkg::ADDR_W-1:0]      address,
   output logic                             chip_select_first_n,
   output logic                             chip_select_second,
   output logic                             chip_select_third_n,
   output logic                             byte_write_lane_a_n,
   output logic                             byte_write_lane_b_n,
   output logic [fbsp_pkg::DATA_W-1:0]      wdata
);
   logic        pend = 1'b0;
   logic        wmode = 1'b0;
   logic [19:0] pend_v = 20'h0_0000;
   // ==========================================================
   // idle pins
   initial
   begin
      advance_or_load = 1'b0;
      read_not_write = 1'b1;
      address = 21'h00_0000;
      {chip_select_first_n, chip_select_second, chip_select_third_n} = 3'h7;
      {byte_write_lane_b_n, byte_write_lane_a_n} = 2'h3;
      wdata = 18'h0_0000;
   end
   // ==========================================================
   // one command per cycle, called at the falling edge
   task automatic op(input logic adv, input logic rnw, input logic [2:0] cs,
                     input logic [20:0] a, input logic [19:0] lnd);
      advance_or_load = adv;
      read_not_write = adv ? ~read_not_write : rnw;
      address = adv ? ~address : a;
      {chip_select_first_n, chip_select_second, chip_select_third_n} =
         adv ? ~{chip_select_first_n, chip_select_second,
                 chip_select_third_n} : cs;
      // released data lines toggle so stale values never match
      {byte_write_lane_b_n, byte_write_lane_a_n, wdata} =
         pend ? pend_v : {2'h3, ~wdata};
      if (!adv)
         wmode = !rnw && cs == 3'b010;
      pend = wmode;
      pend_v = lnd;
      @(posedge sys_clk);
      @(negedge sys_clk);
   endtask : op
endmodule : fbsp_ctrl_model

// ---- bench/fbsp_port_tb_top.sv ----
// self-checking bench for the flow-through burst memory port
`timescale 1ns/10ps
module fbsp_port_tb_top;
   logic        sys_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        sleep_request = 1'b0;
   logic        burst_order_select_n = 1'b1;
   logic        clock_hold_n = 1'b0;
   logic        output_enable_n = 1'b0;
   logic        adv, rnw, cs1n, cs2, cs3n, lan, lbn;
   logic [20:0] addr;
   logic [17:0] wdata;
   logic [8:0]  qa, qb;
   logic        data_oe, write_ready;
   logic [17:0] mem [logic [20:0]];
   logic [31:0] rng = 32'h0000_0025;
   logic [20:0] base;
   int          error_cnt = 0;
   int          cmp_count = 0;
   int          cyc = 0;
   // ==========================================================
   // clock, design and controller
   initial
   begin
      forever #50 sys_clk = ~sys_clk;
   end
   fbsp_port u_fbsp_port (.sys_clk(sys_clk), .resetn(resetn),
      .sleep_request(sleep_request),
      .burst_order_select_n(burst_order_select_n),
      .advance_or_load(adv), .read_not_write(rnw), .address(addr),
      .chip_select_first_n(cs1n), .chip_select_second(cs2),
      .chip_select_third_n(cs3n), .byte_write_lane_a_n(lan),
      .byte_write_lane_b_n(lbn), .clock_hold_n(clock_hold_n),
      .output_enable_n(output_enable_n), .data_lane_a_in(wdata[8:0]),
      .data_lane_b_in(wdata[17:9]), .data_lane_a_out(qa),
      .data_lane_b_out(qb), .data_oe(data_oe), .write_ready(write_ready));
   fbsp_ctrl_model u_fbsp_ctrl_model (.sys_clk(sys_clk),
      .advance_or_load(adv), .read_not_write(rnw), .address(addr),
      .chip_select_first_n(cs1n), .chip_select_second(cs2),
      .chip_select_third_n(cs3n), .byte_write_lane_a_n(lan),
      .byte_write_lane_b_n(lbn), .wdata(wdata));
   // ==========================================================
   // helpers
   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction : xs
   function automatic logic [20:0] nxt(logic [20:0] a, logic [1:0] k);
      logic [1:0] lo;
      lo = burst_order_select_n ? a[1:0] ^ k : a[1:0] + k;
      return {a[20:2], lo};
   endfunction : nxt
   task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic ckb(input logic seen, input logic exp);
      chk({17'h0_0000, seen}, {17'h0_0000, exp});
   endtask : ckb
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : print_verdict
   // n beats from base; random lanes unless full
   task automatic burst(input logic wr, input logic full, input int n);
      logic [1:0]  ln;
      logic [17:0] d;
      logic [20:0] x;
      for (int k = 0; k < n; k++)
      begin
         x = nxt(base, 2'(k));
         d = 18'(xs());
         ln = full ? 2'h0 : 2'(xs());
         if (wr)
         begin
            if (!ln[0])
               mem[x][8:0] = d[8:0];
            if (!ln[1])
               mem[x][17:9] = d[17:9];
            u_fbsp_ctrl_model.op(k != 0, 1'b0, 3'b010, base, {ln, d});
            ckb(data_oe, 1'b0);
            ckb(write_ready, 1'b1);
         end
         else
         begin
            u_fbsp_ctrl_model.op(k != 0, 1'b1, 3'b010, base, 20'h0_0000);
            chk({qb, qa}, mem[x]);
            ckb(data_oe, 1'b1);
         end
      end
   endtask : burst
   // ==========================================================
   // timeout
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         error_cnt++;
         print_verdict();
      end
   end
   // ==========================================================
   // main sequence
   initial
   begin
      repeat (3) @(negedge sys_clk);
      resetn = 1'b1;
      ckb(data_oe, 1'b0);
      ckb(write_ready, 1'b1);
      for (int it = 0; it < 24; it++)
      begin
         burst_order_select_n = it[0];
         base = it == 0 ? 21'h1F_FFFF : 21'(xs());
         burst(1'b1, 1'b1, 4);
         burst(1'b1, 1'b0, 5);
         burst(1'b0, 1'b0, 5);
      end
      for (int c = 0; c < 8; c++)
      begin
         if (c != 2)
         begin
            burst(1'b0, 1'b0, 1);
            u_fbsp_ctrl_model.op(1'b0, 1'b1, 3'(c), base, 20'h0_0000);
            ckb(data_oe, 1'b0);
            u_fbsp_ctrl_model.op(1'b1, 1'b1, 3'b010, base, 20'h0_0000);
            ckb(data_oe, 1'b0);
         end
      end
      burst(1'b0, 1'b0, 1);
      output_enable_n = 1'b1;
      #1 ckb(data_oe, 1'b0);
      u_fbsp_ctrl_model.op(1'b1, 1'b1, 3'b010, base, 20'h0_0000);
      ckb(data_oe, 1'b0);
      output_enable_n = 1'b0;
      #1 chk({qb, qa}, mem[nxt(base, 2'h1)]);
      burst(1'b0, 1'b0, 1);
      clock_hold_n = 1'b1;
      repeat (2) u_fbsp_ctrl_model.op(1'b1, 1'b1, 3'b010, base, 20'h0_0000);
      chk({qb, qa}, mem[base]);
      ckb(data_oe, 1'b1);
      clock_hold_n = 1'b0;
      u_fbsp_ctrl_model.op(1'b1, 1'b1, 3'b010, base, 20'h0_0000);
      chk({qb, qa}, mem[nxt(base, 2'h1)]);
      // no write pending when sleep is raised
      burst(1'b0, 1'b0, 1);
      sleep_request = 1'b1;
      #1 ckb(data_oe, 1'b0);
      // inputs may still count for two cycles: deselect first
      for (int w = 0; w < 2; w++)
         u_fbsp_ctrl_model.op(1'b0, 1'b1, 3'h7, base, 20'h0_0000);
      u_fbsp_ctrl_model.op(1'b0, 1'b0, 3'b010, base, {2'h0, ~mem[base]});
      u_fbsp_ctrl_model.op(1'b1, 1'b0, 3'b010, base, 20'h0_0000);
      // closing deselect ends the write data phase inside sleep
      u_fbsp_ctrl_model.op(1'b0, 1'b1, 3'h7, base, 20'h0_0000);
      ckb(data_oe, 1'b0);
      sleep_request = 1'b0;
      // wake settling: deselects only
      for (int w = 0; w < 2; w++)
         u_fbsp_ctrl_model.op(1'b0, 1'b1, 3'h7, base, 20'h0_0000);
      burst(1'b0, 1'b0, 1);
      print_verdict();
   end
endmodule : fbsp_port_tb_top
